// >>> verilog/pid_speed_loop.sv
// PID speed loop with output limits, ramp gating and sleep/wake boost sequencing
`timescale 1ns/1ns
module pid_speed_loop #(
   parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [pid_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic run_enable_i,
   input wire logic [15:0] setpoint_i,
   input wire logic [15:0] feedback_i,
   input wire logic [15:0] analog_in1_i,
   output logic [15:0] speed_demand_o,
   output logic motor_enable_o,
   output logic asleep_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic int reg_index(input logic [pid_pkg::ADDR_W-1:0] a);
      int r;
      r = pid_pkg::NREG;
      if (a[1:0] == 2'h0 && int'(a[pid_pkg::ADDR_W-1:2]) < pid_pkg::NREG) begin
         r = int'(a[pid_pkg::ADDR_W-1:2]);
      end
      return r;
   endfunction : reg_index

   function automatic pid_pkg::wide_t zx(input logic [15:0] v);
      return pid_pkg::wide_t'({32'h0000_0000, v});
   endfunction : zx

   function automatic logic [15:0] sat16(input pid_pkg::wide_t v, input pid_pkg::wide_t lo,
                                         input pid_pkg::wide_t hi);
      pid_pkg::wide_t t;
      t = v;
      if (t > hi) begin
         t = hi;
      end
      if (t < lo) begin
         t = lo;
      end
      return t[15:0];
   endfunction : sat16

   function automatic logic [15:0] ramp_step(input logic [15:0] max_speed, input logic [15:0] t);
      pid_pkg::wide_t s;
      s = zx(pid_pkg::FULL_SCALE);
      if (t != 16'h0000) begin
         s = zx(max_speed) / (zx(t) * pid_pkg::TICKS_PER_DSEC);
         if (s < 1) begin
            s = pid_pkg::wide_t'(1);
         end
      end
      return s[15:0];
   endfunction : ramp_step

   // ------------------------------------------------------------
   // Register bus and configuration
   // ------------------------------------------------------------
   logic [15:0] cfg_q [pid_pkg::NCFG];
   logic [15:0] cfg_d [pid_pkg::NCFG];
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   int acc_idx;
   logic wr_en;

   // Control state, declared here because the read path shows it
   pid_pkg::phase_e phase_q;
   pid_pkg::phase_e phase_d;
   logic signed [17:0] err_q;
   logic signed [17:0] err_d;
   logic bypass_q;
   logic bypass_d;
   logic clamp_q;
   logic clamp_d;
   logic [15:0] level;

   assign acc_idx = reg_index(paddr_i);
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && (acc_idx == pid_pkg::NREG);
   assign prdata_o = prdata_q;

   always_comb begin
      for (int i = 0; i < pid_pkg::NCFG; i++) begin
         cfg_d[i] = cfg_q[i];
         // Out-of-range writes saturate to the accepted range
         if (wr_en && acc_idx == i) begin
            cfg_d[i] = pwdata_i[15:0];
            if (pwdata_i[15:0] > pid_pkg::CFG_MAX[i]) begin
               cfg_d[i] = pid_pkg::CFG_MAX[i];
            end
            if (pwdata_i[15:0] < pid_pkg::CFG_MIN[i]) begin
               cfg_d[i] = pid_pkg::CFG_MIN[i];
            end
         end
      end
      prdata_d = prdata_q;
      // Read data captured in the setup cycle, valid through the access phase
      if (psel_i && !penable_i) begin
         prdata_d = 32'h0000_0000;
         if (acc_idx < pid_pkg::NCFG) begin
            prdata_d = {16'h0000, cfg_q[acc_idx]};
         end else if (acc_idx == pid_pkg::IDX_STATUS) begin
            prdata_d[pid_pkg::ST_MOTOR_BIT] = motor_enable_o;
            prdata_d[pid_pkg::ST_ASLEEP_BIT] = asleep_o;
            prdata_d[pid_pkg::ST_BYPASS_BIT] = bypass_q;
            prdata_d[pid_pkg::ST_CLAMP_BIT] = clamp_q;
            prdata_d[pid_pkg::ST_PHASE_LSB +: 3] = 3'(phase_q);
         end else if (acc_idx == pid_pkg::IDX_SPEED) begin
            prdata_d = {16'h0000, level};
         end else if (acc_idx == pid_pkg::IDX_ERROR) begin
            prdata_d = 32'(err_q);
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q <= pid_pkg::CFG_RST;
         prdata_q <= 32'h0000_0000;
      end else begin
         cfg_q <= cfg_d;
         prdata_q <= prdata_d;
      end
   end

   // ------------------------------------------------------------
   // Configuration fields
   // ------------------------------------------------------------
   logic loop_direction;
   pid_pkg::limit_src_e output_limit_source;
   logic [15:0] max_speed_limit;
   logic [15:0] min_speed_limit;
   logic [15:0] proportional_gain;
   logic [15:0] integral_time;
   logic [15:0] derivative_time;
   logic [15:0] ramp_enable_error_threshold;

   assign loop_direction = cfg_q[pid_pkg::IDX_CTRL][pid_pkg::CTRL_DIR_BIT];
   assign output_limit_source = pid_pkg::limit_src_e'(cfg_q[pid_pkg::IDX_CTRL][pid_pkg::CTRL_SRC_LSB +: 2]);
   assign max_speed_limit = cfg_q[pid_pkg::IDX_MAX_SPEED];
   assign min_speed_limit = cfg_q[pid_pkg::IDX_MIN_SPEED];
   assign proportional_gain = cfg_q[pid_pkg::IDX_KP];
   assign integral_time = cfg_q[pid_pkg::IDX_TI];
   assign derivative_time = cfg_q[pid_pkg::IDX_TD];
   assign ramp_enable_error_threshold = cfg_q[pid_pkg::IDX_RAMP_THR];

   // ------------------------------------------------------------
   // Control tick, PID, limits and phase sequencing
   // ------------------------------------------------------------
   logic [31:0] div_q;
   logic [31:0] div_d;
   logic tick;
   pid_pkg::wide_t integ_q;
   pid_pkg::wide_t integ_d;
   pid_pkg::wide_t dterm_q;
   pid_pkg::wide_t dterm_d;
   logic [15:0] sp_prev_q;
   logic [15:0] sp_prev_d;
   logic [15:0] pid_out_q;
   logic [15:0] pid_out_d;
   logic [31:0] tmr_q;
   logic [31:0] tmr_d;
   logic stopping_q;
   logic stopping_d;
   logic [15:0] target;
   ramp_if rmp ();

   assign tick = (div_q == 32'(TICK_CYCLES - 1));

   always_comb begin
      pid_pkg::wide_t err;
      pid_pkg::wide_t dsp;
      pid_pkg::wide_t pid;
      pid_pkg::wide_t upper;
      pid_pkg::wide_t lower;
      pid_pkg::wide_t hold;
      logic hi;
      logic lo;
      logic wake;
      err = '0;
      dsp = '0;
      pid = '0;
      upper = '0;
      lower = '0;
      hold = '0;
      hi = 1'b0;
      lo = 1'b0;
      wake = 1'b0;
      div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
      integ_d = integ_q;
      dterm_d = dterm_q;
      sp_prev_d = sp_prev_q;
      pid_out_d = pid_out_q;
      tmr_d = tmr_q;
      phase_d = phase_q;
      stopping_d = stopping_q;

      // Error in 0.01 % units, sign set by loop direction
      err = loop_direction ? zx(feedback_i) - zx(setpoint_i) : zx(setpoint_i) - zx(feedback_i);
      dsp = zx(setpoint_i) - zx(sp_prev_q);
      if (loop_direction) begin
         dsp = -dsp;
      end
      err_d = err[17:0];

      // Ramps gated on error magnitude; zero threshold keeps them on
      bypass_d = (phase_q == pid_pkg::PH_PID) && (ramp_enable_error_threshold != 16'h0000) &&
                 (((err < 0) ? -err : err) < zx(ramp_enable_error_threshold));

      // P + I + D; I off for zero integral time
      pid = (zx(proportional_gain) * err) / pid_pkg::GAIN_SCALE + dterm_q;
      if (integral_time != 16'h0000) begin
         pid = pid + integ_q / (zx(integral_time) * pid_pkg::TICKS_PER_SEC);
      end

      // Output limit selection
      upper = zx(max_speed_limit);
      lower = zx(min_speed_limit);
      unique case (output_limit_source)
         pid_pkg::LIM_DIGITAL: begin
            upper = zx(cfg_q[pid_pkg::IDX_UPPER_FRAC]) * zx(max_speed_limit) / zx(pid_pkg::FULL_SCALE);
            lower = zx(cfg_q[pid_pkg::IDX_LOWER_FRAC]) * zx(max_speed_limit) / zx(pid_pkg::FULL_SCALE);
         end
         pid_pkg::LIM_AIN_MAX: begin
            upper = zx(analog_in1_i);
         end
         pid_pkg::LIM_AIN_MIN: begin
            lower = zx(analog_in1_i);
         end
         pid_pkg::LIM_AIN_OFFSET: begin
            pid = pid + zx(analog_in1_i);
         end
      endcase
      if (lower > upper) begin
         lower = upper;
      end
      hi = pid > upper;
      lo = pid < lower;
      clamp_d = hi || lo;

      if (tick) begin
         pid_out_d = sat16(pid, lower, upper);
         sp_prev_d = setpoint_i;
         dterm_d = zx(proportional_gain) * zx(derivative_time) * dsp;
         // Integrator frozen while the output is held at a limit by the error
         if (integral_time == 16'h0000 || phase_q != pid_pkg::PH_PID) begin
            integ_d = '0;
         end else if (!((hi && err > 0) || (lo && err < 0))) begin
            integ_d = integ_q + zx(proportional_gain) * err;
         end
         tmr_d = tmr_q + 32'h0000_0001;
      end

      // Wake when feedback reaches the wake level from the sleeping side
      wake = loop_direction ? (feedback_i >= cfg_q[pid_pkg::IDX_WAKE_LVL]) :
                              (feedback_i <= cfg_q[pid_pkg::IDX_WAKE_LVL]);

      unique case (phase_q)
         pid_pkg::PH_IDLE: begin
            tmr_d = 32'h0000_0000;
            stopping_d = 1'b0;
            if (run_enable_i) begin
               phase_d = (cfg_q[pid_pkg::IDX_WAKE_HOLD] != 16'h0000) ? pid_pkg::PH_WAKE_BOOST : pid_pkg::PH_PID;
            end
         end
         pid_pkg::PH_WAKE_BOOST: begin
            hold = zx(cfg_q[pid_pkg::IDX_WAKE_HOLD]) * pid_pkg::TICKS_PER_SEC;
            if (!run_enable_i) begin
               stopping_d = 1'b1;
               tmr_d = 32'h0000_0000;
               phase_d = (cfg_q[pid_pkg::IDX_SLEEP_HOLD] != 16'h0000) ? pid_pkg::PH_SLEEP_BOOST : pid_pkg::PH_IDLE;
            end else if (pid_pkg::wide_t'({16'h0000, tmr_q}) >= hold) begin
               tmr_d = 32'h0000_0000;
               phase_d = pid_pkg::PH_PID;
            end
         end
         pid_pkg::PH_PID: begin
            hold = zx(cfg_q[pid_pkg::IDX_STANDBY]) * pid_pkg::TICKS_PER_SEC;
            if (level >= cfg_q[pid_pkg::IDX_SLEEP_LVL]) begin
               tmr_d = 32'h0000_0000;
            end
            if (!run_enable_i) begin
               stopping_d = 1'b1;
               tmr_d = 32'h0000_0000;
               phase_d = (cfg_q[pid_pkg::IDX_SLEEP_HOLD] != 16'h0000) ? pid_pkg::PH_SLEEP_BOOST : pid_pkg::PH_IDLE;
            end else if (cfg_q[pid_pkg::IDX_STANDBY] != 16'h0000 && pid_pkg::wide_t'({16'h0000, tmr_q}) >= hold) begin
               tmr_d = 32'h0000_0000;
               phase_d = (cfg_q[pid_pkg::IDX_SLEEP_HOLD] != 16'h0000) ? pid_pkg::PH_SLEEP_BOOST : pid_pkg::PH_ASLEEP;
            end
         end
         pid_pkg::PH_SLEEP_BOOST: begin
            hold = zx(cfg_q[pid_pkg::IDX_SLEEP_HOLD]) * pid_pkg::TICKS_PER_SEC;
            if (pid_pkg::wide_t'({16'h0000, tmr_q}) >= hold) begin
               tmr_d = 32'h0000_0000;
               phase_d = (stopping_q || !run_enable_i) ? pid_pkg::PH_IDLE : pid_pkg::PH_ASLEEP;
            end
         end
         pid_pkg::PH_ASLEEP: begin
            tmr_d = 32'h0000_0000;
            if (!run_enable_i) begin
               phase_d = pid_pkg::PH_IDLE;
            end else if (wake) begin
               phase_d = (cfg_q[pid_pkg::IDX_WAKE_HOLD] != 16'h0000) ? pid_pkg::PH_WAKE_BOOST : pid_pkg::PH_PID;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q <= 32'h0000_0000;
         integ_q <= '0;
         dterm_q <= '0;
         sp_prev_q <= 16'h0000;
         pid_out_q <= 16'h0000;
         tmr_q <= 32'h0000_0000;
         phase_q <= pid_pkg::PH_IDLE;
         stopping_q <= 1'b0;
         err_q <= '0;
         bypass_q <= 1'b0;
         clamp_q <= 1'b0;
      end else begin
         div_q <= div_d;
         integ_q <= integ_d;
         dterm_q <= dterm_d;
         sp_prev_q <= sp_prev_d;
         pid_out_q <= pid_out_d;
         tmr_q <= tmr_d;
         phase_q <= phase_d;
         stopping_q <= stopping_d;
         err_q <= err_d;
         bypass_q <= bypass_d;
         clamp_q <= clamp_d;
      end
   end

   // ------------------------------------------------------------
   // Speed target and ramp
   // ------------------------------------------------------------
   always_comb begin
      unique case (phase_q)
         pid_pkg::PH_WAKE_BOOST: target = cfg_q[pid_pkg::IDX_WAKE_SPEED];
         pid_pkg::PH_PID: target = pid_out_q;
         pid_pkg::PH_SLEEP_BOOST: target = cfg_q[pid_pkg::IDX_SLEEP_SPEED];
         default: target = 16'h0000;
      endcase
   end

   assign rmp.tick = tick;
   assign rmp.bypass = bypass_q;
   assign rmp.target = target;
   assign rmp.step_up = ramp_step(max_speed_limit, cfg_q[pid_pkg::IDX_ACCEL]);
   assign rmp.step_dn = ramp_step(max_speed_limit, cfg_q[pid_pkg::IDX_DECEL]);
   assign level = rmp.level;

   ramp_gen u_ramp (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .rmp(rmp.gen)
   );

   assign speed_demand_o = level;
   assign motor_enable_o = (phase_q == pid_pkg::PH_WAKE_BOOST) || (phase_q == pid_pkg::PH_PID) ||
                           (phase_q == pid_pkg::PH_SLEEP_BOOST);
   assign asleep_o = (phase_q == pid_pkg::PH_ASLEEP);

endmodule : pid_speed_loop

// >>> verilog/pid_pkg.sv
// Constants, register map and types of the PID speed loop with sleep and wake
package pid_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int TICKS_PER_SEC = 1000;
   localparam int TICKS_PER_DSEC = 100;
   localparam int GAIN_SCALE = 10;

   // ------------------------------------------------------------
   // Scaling: quantities in units of 0.01 % of full scale
   // ------------------------------------------------------------
   localparam logic [15:0] FULL_SCALE = 16'h2710;

   // ------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ------------------------------------------------------------
   localparam int IDX_CTRL = 0;
   localparam int IDX_MAX_SPEED = 1;
   localparam int IDX_MIN_SPEED = 2;
   localparam int IDX_ACCEL = 3;
   localparam int IDX_DECEL = 4;
   localparam int IDX_UPPER_FRAC = 5;
   localparam int IDX_LOWER_FRAC = 6;
   localparam int IDX_RAMP_THR = 7;
   localparam int IDX_KP = 8;
   localparam int IDX_TI = 9;
   localparam int IDX_TD = 10;
   localparam int IDX_SLEEP_LVL = 11;
   localparam int IDX_STANDBY = 12;
   localparam int IDX_WAKE_LVL = 13;
   localparam int IDX_WAKE_HOLD = 14;
   localparam int IDX_SLEEP_HOLD = 15;
   localparam int IDX_WAKE_SPEED = 16;
   localparam int IDX_SLEEP_SPEED = 17;
   localparam int NCFG = 18;
   localparam int IDX_STATUS = 18;
   localparam int IDX_SPEED = 19;
   localparam int IDX_ERROR = 20;
   localparam int NREG = 21;
   localparam int ADDR_W = 8;

   // CTRL fields
   localparam int CTRL_DIR_BIT = 0;
   localparam int CTRL_SRC_LSB = 1;

   // STATUS fields
   localparam int ST_MOTOR_BIT = 0;
   localparam int ST_ASLEEP_BIT = 1;
   localparam int ST_BYPASS_BIT = 2;
   localparam int ST_CLAMP_BIT = 3;
   localparam int ST_PHASE_LSB = 4;

   typedef enum logic [1:0] {
      LIM_DIGITAL = 2'h0,
      LIM_AIN_MAX = 2'h1,
      LIM_AIN_MIN = 2'h2,
      LIM_AIN_OFFSET = 2'h3
   } limit_src_e;

   typedef enum {PH_IDLE, PH_WAKE_BOOST, PH_PID, PH_SLEEP_BOOST, PH_ASLEEP} phase_e;

   typedef logic signed [47:0] wide_t;

   // Reset values, lowest and highest accepted values per register
   localparam logic [15:0] CFG_RST [NCFG] = '{16'h0000, FULL_SCALE, 16'h0000, 16'h0032, 16'h0032,
      FULL_SCALE, 16'h0000, 16'h0000, 16'h000a, 16'h000a, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] CFG_MIN [NCFG] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [15:0] CFG_MAX [NCFG] = '{16'h0007, FULL_SCALE, FULL_SCALE, 16'hffff, 16'hffff,
      FULL_SCALE, FULL_SCALE, FULL_SCALE, 16'h012c, 16'h012c, 16'h0064, FULL_SCALE, 16'hffff,
      FULL_SCALE, 16'hffff, 16'hffff, FULL_SCALE, FULL_SCALE};

endpackage : pid_pkg

// >>> verilog/ramp_if.sv
// Interface between the loop controller and the ramp generator
`timescale 1ns/1ns
interface ramp_if;
   logic tick;
   logic bypass;
   logic [15:0] target;
   logic [15:0] step_up;
   logic [15:0] step_dn;
   logic [15:0] level;

   modport ctl (output tick, bypass, target, step_up, step_dn, input level);
   modport gen (input tick, bypass, target, step_up, step_dn, output level);
endinterface : ramp_if

// >>> verilog/ramp_gen.sv
// Accel and decel ramp toward the demanded speed, one step per control tick
`timescale 1ns/1ns
module ramp_gen (
   input wire logic clk_i,
   input wire logic arst_n_i,
   ramp_if.gen rmp
);

   logic [15:0] level_q;
   logic [15:0] level_d;

   // ------------------------------------------------------------
   // Step toward target
   // ------------------------------------------------------------
   always_comb begin
      level_d = level_q;
      if (rmp.tick) begin
         if (rmp.bypass) begin
            level_d = rmp.target;
         end else if (level_q < rmp.target) begin
            level_d = ((rmp.target - level_q) > rmp.step_up) ? level_q + rmp.step_up : rmp.target;
         end else if (level_q > rmp.target) begin
            level_d = ((level_q - rmp.target) > rmp.step_dn) ? level_q - rmp.step_dn : rmp.target;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         level_q <= 16'h0000;
      end else begin
         level_q <= level_d;
      end
   end

   assign rmp.level = level_q;

endmodule : ramp_gen

// >>> verification/motor_stage.sv
// Behavioural model of the motor control stage that receives the speed demand
`timescale 1ns/1ns
module motor_stage (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [15:0] demand_i,
   input wire logic enable_i,
   output logic [15:0] shaft_o
);
   // Shaft follows the demand while the output stage is enabled, otherwise drops to zero at the next clock
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) shaft_o <= 16'h0000;
      else shaft_o <= enable_i ? demand_i : 16'h0000;
   end
endmodule : motor_stage

// >>> verification/pid_speed_loop_props.sv
// Port-level assertions of the PID speed loop
`timescale 1ns/1ns
module pid_speed_loop_props (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [pid_pkg::ADDR_W-1:0] paddr_i,
   input logic [31:0] prdata_o,
   input logic pslverr_o,
   input wire logic run_enable_i,
   input logic [15:0] speed_demand_o,
   input logic motor_enable_o,
   input logic asleep_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   a_sleep_no_motor: assert property (asleep_o |-> !motor_enable_o)
      else $error("motor enabled while asleep");
   a_sleep_from_run: assert property ($rose(asleep_o) |-> $past(motor_enable_o))
      else $error("sleep entered while stopped");
   a_idle_zero: assert property (!motor_enable_o && speed_demand_o == 16'h0000 |=> speed_demand_o == 16'h0000)
      else $error("demand rose while output off");
   a_start_motor: assert property ($rose(run_enable_i) && !motor_enable_o && !asleep_o |=> motor_enable_o)
      else $error("no start after enable");
   a_wake_motor: assert property ($fell(asleep_o) && run_enable_i |-> motor_enable_o)
      else $error("wake without motor output");
   a_demand_bound: assert property (speed_demand_o <= 16'h2710)
      else $error("demand above full scale");
   a_unmapped_err: assert property (psel_i && penable_i && paddr_i >= 8'h54 |-> pslverr_o)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (psel_i && penable_i && paddr_i < 8'h54 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
      else $error("mapped access refused");
   a_refused_zero: assert property (psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
      else $error("refused read returned data");
   c_sleep: cover property ($rose(asleep_o));
   c_wake: cover property ($fell(asleep_o) && motor_enable_o);
   c_refused: cover property (pslverr_o);
endmodule : pid_speed_loop_props
bind pid_speed_loop pid_speed_loop_props pid_speed_loop_props_i (.*);

// >>> verification/test_pid_speed_loop.sv
// Self-checking bench of the PID speed loop over APB
`timescale 1ns/1ns
module test_pid_speed_loop;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, run_enable_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, v;
   logic pready_o, pslverr_o, motor_enable_o, asleep_o;
   logic [15:0] setpoint_i = 16'h0000, feedback_i = 16'h0000, analog_in1_i = 16'h0000, speed_demand_o, shaft;
   int miscompares = 0, checks = 0, cyc = 0;
   logic [7:0] ra [8] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h30};
   logic [31:0] rv [8] = '{32'h2710, 32'h32, 32'h32, 32'h2710, 32'ha, 32'ha, 32'h0, 32'h0};
   logic [15:0] ain [3] = '{16'h0bb8, 16'h1388, 16'h03e8};
   logic [15:0] lx [3] = '{16'h0bb8, 16'h1388, 16'h1388};
   pid_speed_loop #(.TICK_CYCLES(20)) pid_speed_loop_i (.*);
   motor_stage motor_stage_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .demand_i(speed_demand_o),
      .enable_i(motor_enable_o), .shaft_o(shaft));
   initial forever #5 clk_i = ~clk_i;
   // ------------------------------------------------------------
   // Bus cycles and comparisons
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      v = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      apb(1'b1, a, d);
      apb(1'b0, a, 32'h0);
      chk(v, e);
   endtask : wrc
   task automatic st(input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, 8'h48, 32'h0);
      chk(v & m, e);
   endtask : st
   task automatic tk(input int n);
      repeat (n * 20) @(posedge clk_i);
   endtask : tk
   task automatic go(input logic [15:0] sp, input logic [15:0] fb, input logic [15:0] e);
      setpoint_i <= sp;
      feedback_i <= fb;
      tk(5);
      chk({16'h0, speed_demand_o}, {16'h0, e});
   endtask : go
   task automatic give_verdict();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 85000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk(v, rv[i]);
      end
      wrc(8'h54, 32'h1, 32'h0);
      wrc(8'h20, 32'h0, 32'h1);
      wrc(8'h20, 32'h3e8, 32'h12c);
      wrc(8'h24, 32'h3e8, 32'h12c);
      wrc(8'h28, 32'hc8, 32'h64);
      wrc(8'h28, 32'h0, 32'h0);
      wr(8'h0c, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h24, 32'h0);
      wr(8'h20, 32'h14);
      wr(8'h04, 32'h1f40);
      run_enable_i <= 1'b1;
      go(16'h0bb8, 16'h03e8, 16'h0fa0);
      apb(1'b0, 8'h50, 32'h0);
      chk(v, 32'h7d0);
      wr(8'h14, 32'h1388);
      wr(8'h18, 32'h7d0);
      go(16'h1388, 16'h03e8, 16'h0fa0);
      go(16'h01f4, 16'h03e8, 16'h0640);
      wr(8'h14, 32'h2710);
      wr(8'h18, 32'h0);
      for (int i = 1; i < 4; i++) begin
         wr(8'h00, 32'(i * 2));
         analog_in1_i <= ain[i-1];
         go(16'h0bb8, 16'h03e8, lx[i-1]);
      end
      wr(8'h00, 32'h1);
      go(16'h03e8, 16'h0bb8, 16'h0fa0);
      wr(8'h00, 32'h0);
      wr(8'h0c, 32'h1);
      go(16'h0bb8, 16'h03e8, 16'h0fa0);
      st(32'h4, 32'h0);
      setpoint_i <= 16'h1f40;
      tk(3);
      chk({31'h0, speed_demand_o > 16'h0fa0 && speed_demand_o <= 16'h1090}, 32'h1);
      wr(8'h1c, 32'h1388);
      go(16'h0fa0, 16'h03e8, 16'h1770);
      st(32'h4, 32'h4);
      setpoint_i <= 16'h1f40;
      tk(3);
      st(32'h4, 32'h0);
      wr(8'h0c, 32'h0);
      wr(8'h1c, 32'h0);
      go(16'h0fa0, 16'h03e8, 16'h1770);
      wr(8'h24, 32'ha);
      tk(100);
      chk({31'h0, speed_demand_o > 16'h1770 && speed_demand_o < 16'h19c8}, 32'h1);
      tk(300);
      setpoint_i <= 16'h03e8;
      tk(3);
      chk({31'h0, speed_demand_o >= 16'h07d0 && speed_demand_o < 16'h0834}, 32'h1);
      wr(8'h2c, 32'h2328);
      tk(20);
      chk({31'h0, asleep_o}, 32'h0);
      wr(8'h30, 32'h1);
      tk(500);
      chk({31'h0, asleep_o}, 32'h0);
      tk(600);
      chk({30'h0, asleep_o, motor_enable_o}, 32'h2);
      wr(8'h30, 32'h0);
      wr(8'h34, 32'h1f4);
      wr(8'h38, 32'h1);
      wr(8'h40, 32'h1770);
      tk(3);
      chk({31'h0, asleep_o}, 32'h1);
      feedback_i <= 16'h0190;
      tk(3);
      st(32'h70, 32'h10);
      chk({16'h0, speed_demand_o}, 32'h1770);
      tk(985);
      st(32'h70, 32'h10);
      tk(15);
      st(32'h70, 32'h20);
      wr(8'h3c, 32'h1);
      wr(8'h44, 32'h1b58);
      run_enable_i <= 1'b0;
      tk(3);
      st(32'h70, 32'h30);
      chk({16'h0, speed_demand_o}, 32'h1b58);
      tk(1000);
      st(32'h73, 32'h0);
      chk({16'h0, shaft}, 32'h0);
      give_verdict();
   end
endmodule : test_pid_speed_loop
